// file: common/rtcbus_pkg.sv
`default_nettype none
package rtcbus_pkg;
  // Data space offsets.
  localparam logic [7:0] ADDR_STATUS0   = 8'h00;
  localparam logic [7:0] ADDR_STATUS1   = 8'h01;
  localparam logic [7:0] ADDR_STATUS2   = 8'h02;
  localparam logic [7:0] ADDR_TRIM      = 8'h10;
  localparam logic [7:0] ADDR_CLK_FIRST = 8'h20;
  localparam logic [7:0] ADDR_CLK_LAST  = 8'h28;
  localparam logic [7:0] ADDR_ALM_FIRST = 8'h30;
  localparam logic [7:0] ADDR_ALM_LAST  = 8'h34;
  localparam logic [7:0] ADDR_TMR_FIRST = 8'h40;
  localparam logic [7:0] ADDR_TMR_LAST  = 8'h43;
  localparam logic [7:0] ADDR_USR_FIRST = 8'h50;
  localparam logic [7:0] ADDR_USR_LAST  = 8'h5F;
  localparam logic [7:0] CMD_BOTH       = 8'hF0;
  localparam logic [7:0] CMD_CLOCK      = 8'hF1;
  localparam logic [7:0] CMD_TIMER      = 8'hF2;
  // Counts of locations.
  localparam int CLK_BYTES = 9;
  localparam int ALM_BYTES = 5;
  localparam int TMR_BYTES = 4;
  localparam int USR_BYTES = 16;
  // Status word 2 fields.
  localparam int STAT2_INIT_BIT  = 4;
  localparam int STAT2_TUNE_BIT  = 0;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;
  // Access kinds recognised by the strobe decoder.
  typedef enum logic [1:0] {
    ACC_NONE  = 2'b00,
    ACC_READ  = 2'b01,
    ACC_WRITE = 2'b10
  } rtcbus_acc_type;
endpackage
`default_nettype wire

// file: rtl/rtcbus_strobe.sv
`default_nettype none
// ==========================================================
// Strobe decoder for both host bus styles
// ==========================================================
module rtcbus_strobe
(
  input  wire logic           clk,
  input  wire logic           resetn,
  input  wire logic           style_rw,
  input  wire logic           cs_n,
  input  wire logic           wr_pin,
  input  wire logic           rd_pin,
  input  wire logic           block,
  output rtcbus_pkg::rtcbus_acc_type acc_level,
  output logic                acc_start
);
  import rtcbus_pkg::*;

  rtcbus_acc_type prev_r;
  rtcbus_acc_type prev_nxt;

  // Separate strobes or direction plus data strobe, per bus style.
  always_comb begin
    acc_level = ACC_NONE;
    if (!block && !cs_n && !rd_pin && !style_rw && wr_pin) begin // RULE_14
      acc_level = ACC_READ;
    end else if (!block && !cs_n && rd_pin && !style_rw && !wr_pin) begin
      acc_level = ACC_WRITE;
    end else if (!block && !cs_n && !rd_pin && style_rw) begin
      acc_level = wr_pin ? ACC_READ : ACC_WRITE; // RULE_14
    end
  end

  always_comb begin
    prev_nxt = acc_level;
  end

  // A transfer acts once, on the first cycle its strobe is seen.
  assign acc_start = (acc_level != ACC_NONE) && (prev_r != acc_level);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      prev_r <= ACC_NONE;
    end else begin
      prev_r <= prev_nxt;
    end
  end
endmodule
`default_nettype wire

// file: rtl/rtcbus_core.sv
`default_nettype none
// Operation
// RULE_01: Power fail low blocks bus inputs and floats all eight lines.
// RULE_02: Alarm interrupt still pulls the request low during standby.
// RULE_03: Host writes one then zero to status 2 bit 4.
// RULE_04: That write pair sets tuning mode and clears other status bits.
// RULE_05: Host loads time copies then issues clock command with a write.
// RULE_06: Without tuning the host writes 210 to the trimming register.
// RULE_07: Host clears tuning mode only after writing the trimming register.
// RULE_08: Hidden timekeeping area is reachable only through commands.
// RULE_09: Every data space location is readable and writable.
// RULE_10: Sixteen user bytes live at 50 to 5F hex.
// RULE_11: User bytes keep their contents during standby.
// RULE_12: Commands and time set lock never touch user bytes.
// RULE_13: Host sets address/data select before chip select and strobe.
// RULE_14: Strobe pins act in separate-strobe or direction-line style.
// RULE_15: Host must not trust register contents after power-up.
// RULE_16: Data space holds three status registers.
// RULE_17: Nine time and date copies, loaded or transferred by command.
// RULE_18: Five host-writable alarm locations.
// RULE_19: Four timer copies, loaded or transferred by command.
// RULE_20: Three commands move copies to and from the hidden area.
// RULE_21: Select low means address byte, high means data byte.
// RULE_22: Data accesses hit the latched address until a new one.
// RULE_23: Command read loads copies; command write stores hidden area.
// RULE_24: Read with select low returns the address latch.
// RULE_25: Bus driven only with chip select, read and no power fail.
module rtcbus_core
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        style_rw,
  input  wire logic        power_fail_n,
  input  wire logic        cs_n,
  input  wire logic        wr_pin,
  input  wire logic        rd_pin,
  input  wire logic        addr_data_sel,
  input  wire logic [7:0]  muxed_bus_in,
  output logic      [7:0]  muxed_bus_out,
  output logic             muxed_bus_oe,
  input  wire logic        alarm_event,
  input  wire logic        alarm_unmasked,
  output logic             irq_n_out,
  output logic             irq_n_oe,
  output logic             tune_mode,
  output logic      [7:0]  trim_value
);
  import rtcbus_pkg::*;

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  logic [13:0] sync1_r;
  logic [13:0] sync2_r;
  logic [13:0] sync_nxt;
  logic        pf_n_s;
  logic        cs_n_s;
  logic        wr_s;
  logic        rd_s;
  logic        sel_s;
  logic [7:0]  bus_s;

  // Pins other than style_rw and alarm_unmasked cross into the clock domain through two flops before use.
  always_comb begin
    sync_nxt = {power_fail_n, cs_n, wr_pin, rd_pin, addr_data_sel,
                muxed_bus_in, alarm_event};
  end

  always_ff @(posedge clk) begin
    sync1_r <= sync_nxt;
    sync2_r <= sync1_r;
  end

  assign pf_n_s = sync2_r[13];
  assign cs_n_s = sync2_r[12];
  assign wr_s   = sync2_r[11];
  assign rd_s   = sync2_r[10];
  assign sel_s  = sync2_r[9];
  assign bus_s  = sync2_r[8:1];

  // ==========================================================
  // Strobe decoding
  // ==========================================================
  rtcbus_acc_type acc_level;
  logic           acc_start;
  logic           standby;

  assign standby = !pf_n_s; // RULE_01

  rtcbus_strobe u_strobe (
    .clk       (clk),
    .resetn    (resetn),
    .style_rw  (style_rw),
    .cs_n      (cs_n_s),
    .wr_pin    (wr_s),
    .rd_pin    (rd_s),
    .block     (standby),
    .acc_level (acc_level),
    .acc_start (acc_start)
  );

  // ==========================================================
  // Storage
  // ==========================================================
  logic [7:0] addr_r;
  logic [7:0] addr_nxt;
  logic [7:0] stat_r [3];
  logic [7:0] stat_nxt [3];
  logic [7:0] trim_r;
  logic [7:0] trim_nxt;
  logic [7:0] clk_r [CLK_BYTES];
  logic [7:0] clk_nxt [CLK_BYTES];
  logic [7:0] alm_r [ALM_BYTES];
  logic [7:0] alm_nxt [ALM_BYTES];
  logic [7:0] tmr_r [TMR_BYTES];
  logic [7:0] tmr_nxt [TMR_BYTES];
  logic [7:0] usr_r [USR_BYTES];
  logic [7:0] usr_nxt [USR_BYTES];
  logic [7:0] hclk_r [CLK_BYTES];
  logic [7:0] hclk_nxt [CLK_BYTES];
  logic [7:0] htmr_r [TMR_BYTES];
  logic [7:0] htmr_nxt [TMR_BYTES];
  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;
  logic       irq_r;
  logic       irq_nxt;

  logic is_wr;
  logic is_rd;
  logic cmd_clk;
  logic cmd_tmr;

  // True when an address falls in a window of the map.
  function automatic logic in_range(input logic [7:0] a,
                                    input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  assign is_wr   = acc_start && (acc_level == ACC_WRITE) && sel_s;
  assign is_rd   = acc_start && (acc_level == ACC_READ) && sel_s;
  assign cmd_clk = (addr_r == CMD_BOTH) || (addr_r == CMD_CLOCK); // RULE_20
  assign cmd_tmr = (addr_r == CMD_BOTH) || (addr_r == CMD_TIMER); // RULE_20

  // ==========================================================
  // Next-state of the data space and hidden area
  // ==========================================================
  always_comb begin
    addr_nxt  = addr_r;
    stat_nxt  = stat_r;
    trim_nxt  = trim_r;
    clk_nxt   = clk_r;
    alm_nxt   = alm_r;
    tmr_nxt   = tmr_r;
    usr_nxt   = usr_r;
    hclk_nxt  = hclk_r;
    htmr_nxt  = htmr_r;
    // Address byte is latched when select is low.
    if (acc_start && acc_level == ACC_WRITE && !sel_s) begin
      addr_nxt = bus_s; // RULE_21
    end
    // Data writes go to the latched location only, except the init pair, which also clears status 0 and 1; user bytes are
    // never in the path of a command, which keeps them intact.
    if (is_wr) begin // RULE_22
      if (addr_r == ADDR_STATUS2 && stat_r[2][STAT2_INIT_BIT]
          && !bus_s[STAT2_INIT_BIT]) begin
        stat_nxt[0] = STAT_RESET; // RULE_04
        stat_nxt[1] = STAT_RESET;
        stat_nxt[2] = STAT_RESET;
        stat_nxt[2][STAT2_TUNE_BIT] = 1'b1; // RULE_04
      end else if (in_range(addr_r, ADDR_STATUS0, ADDR_STATUS2)) begin
        stat_nxt[addr_r[1:0]] = bus_s; // RULE_16 RULE_09
      end
      if (addr_r == ADDR_TRIM) begin
        trim_nxt = bus_s; // RULE_09
      end
      if (in_range(addr_r, ADDR_CLK_FIRST, ADDR_CLK_LAST)) begin
        clk_nxt[addr_r[3:0]] = bus_s; // RULE_17
      end
      if (in_range(addr_r, ADDR_ALM_FIRST, ADDR_ALM_LAST)) begin
        alm_nxt[addr_r[2:0]] = bus_s; // RULE_18
      end
      if (in_range(addr_r, ADDR_TMR_FIRST, ADDR_TMR_LAST)) begin
        tmr_nxt[addr_r[1:0]] = bus_s; // RULE_19
      end
      if (in_range(addr_r, ADDR_USR_FIRST, ADDR_USR_LAST)) begin
        usr_nxt[addr_r[3:0]] = bus_s; // RULE_10
      end
      // Command write stores copies into the hidden area.
      if (cmd_clk) begin // RULE_12
        hclk_nxt = clk_r; // RULE_23 RULE_08
      end
      if (cmd_tmr) begin
        htmr_nxt = tmr_r; // RULE_23
      end
    end
    // Command read loads copies from the hidden area.
    if (is_rd && cmd_clk) begin
      clk_nxt = hclk_r; // RULE_23 RULE_17
    end
    if (is_rd && cmd_tmr) begin
      tmr_nxt = htmr_r; // RULE_23 RULE_19
    end
  end

  // ==========================================================
  // Read data path
  // ==========================================================
  // The hidden area has no address, so it never appears here.
  always_comb begin
    rd_data_nxt = rd_data_r;
    if (acc_start && acc_level == ACC_READ) begin
      rd_data_nxt = BYTE_ZERO;
      if (!sel_s) begin
        rd_data_nxt = addr_r; // RULE_24
      end else if (in_range(addr_r, ADDR_STATUS0, ADDR_STATUS2)) begin
        rd_data_nxt = stat_r[addr_r[1:0]];
      end else if (addr_r == ADDR_TRIM) begin
        rd_data_nxt = trim_r;
      end else if (in_range(addr_r, ADDR_CLK_FIRST, ADDR_CLK_LAST)) begin
        rd_data_nxt = clk_r[addr_r[3:0]];
      end else if (in_range(addr_r, ADDR_ALM_FIRST, ADDR_ALM_LAST)) begin
        rd_data_nxt = alm_r[addr_r[2:0]];
      end else if (in_range(addr_r, ADDR_TMR_FIRST, ADDR_TMR_LAST)) begin
        rd_data_nxt = tmr_r[addr_r[1:0]];
      end else if (in_range(addr_r, ADDR_USR_FIRST, ADDR_USR_LAST)) begin
        rd_data_nxt = usr_r[addr_r[3:0]]; // RULE_10
      end
    end
  end

  // Interrupt is independent of the bus, so standby cannot mask it.
  always_comb begin
    irq_nxt = sync2_r[0] && alarm_unmasked; // RULE_02
  end

  // Storage flops; user bytes and copies are not reset, so they
  // survive standby and a power-fail tied to system reset.
  always_ff @(posedge clk) begin
    stat_r <= stat_nxt;
    trim_r <= trim_nxt;
    clk_r  <= clk_nxt;
    alm_r  <= alm_nxt;
    tmr_r  <= tmr_nxt;
    usr_r  <= usr_nxt; // RULE_11
    hclk_r <= hclk_nxt;
    htmr_r <= htmr_nxt;
    addr_r <= addr_nxt;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rd_data_r <= BYTE_ZERO;
      irq_r     <= 1'b0;
    end else begin
      rd_data_r <= rd_data_nxt;
      irq_r     <= irq_nxt;
    end
  end

  // ==========================================================
  // Pins
  // ==========================================================
  assign muxed_bus_out = rd_data_r;
  assign muxed_bus_oe  = (acc_level == ACC_READ) && !standby; // RULE_25
  assign irq_n_out     = 1'b0;
  assign irq_n_oe      = irq_r; // RULE_02
  assign tune_mode     = stat_r[2][STAT2_TUNE_BIT];
  assign trim_value    = trim_r;

  // ==========================================================
  // Checks
  // ==========================================================
  // Standby must both float the bus and keep the decoder from acting.
  a_standby_float: assert property ( // RULE_01
    @(posedge clk) disable iff (!resetn)
    standby |-> !muxed_bus_oe && (acc_level == ACC_NONE))
    else $error("bus driven in standby");
  a_irq_in_standby: assert property ( // RULE_02
    @(posedge clk) disable iff (!resetn)
    (sync2_r[0] && alarm_unmasked) |=> !irq_n_out && irq_n_oe)
    else $error("alarm irq missing");
  a_init_pair: assert property ( // RULE_04
    @(posedge clk) disable iff (!resetn)
    (is_wr && addr_r == ADDR_STATUS2 && stat_r[2][STAT2_INIT_BIT]
     && !bus_s[STAT2_INIT_BIT])
    |=> (stat_r[2] == (8'h01 << STAT2_TUNE_BIT))
     && (stat_r[0] == STAT_RESET) && (stat_r[1] == STAT_RESET))
    else $error("init pair wrong");
  a_addr_latch: assert property ( // RULE_21
    @(posedge clk) disable iff (!resetn)
    (acc_start && acc_level == ACC_WRITE && !sel_s)
    |=> addr_r == $past(bus_s))
    else $error("address not latched");
  a_addr_hold: assert property ( // RULE_22
    @(posedge clk) disable iff (!resetn)
    (is_wr || is_rd) |=> $stable(addr_r))
    else $error("address moved");
  a_addr_readback: assert property ( // RULE_24
    @(posedge clk) disable iff (!resetn)
    (acc_start && acc_level == ACC_READ && !sel_s)
    |=> rd_data_r == $past(addr_r))
    else $error("latch readback wrong");
  a_cmd_store: assert property ( // RULE_23
    @(posedge clk) disable iff (!resetn)
    (is_wr && addr_r == CMD_CLOCK) |=> hclk_r[0] == $past(clk_r[0]))
    else $error("clock store failed");
  a_user_kept: assert property ( // RULE_12
    @(posedge clk) disable iff (!resetn)
    ((is_wr || is_rd) && addr_r >= CMD_BOTH)
    |=> $stable(usr_r[0]) && $stable(usr_r[USR_BYTES-1]))
    else $error("user byte disturbed");
  a_drive_cond: assert property ( // RULE_25
    @(posedge clk) disable iff (!resetn)
    muxed_bus_oe |-> !cs_n_s && !rd_s && pf_n_s)
    else $error("drive without select");
endmodule
`default_nettype wire

// file: dv/rtcbus_host_model.sv
`default_nettype none
// ==========================================================
// Host processor on the multiplexed byte bus
// ==========================================================
module rtcbus_host_model (
  input  wire logic       clk,
  input  wire logic       style_rw,
  input  wire logic [7:0] muxed_bus_out,
  input  wire logic       muxed_bus_oe,
  output logic            cs_n,
  output logic            wr_pin,
  output logic            rd_pin,
  output logic            addr_data_sel,
  output logic      [7:0] muxed_bus_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       host_oe = 1'b0;
  logic [7:0] host_data = 8'h00;
  logic [7:0] last_level = 8'h00;
  // A released bus must not keep its old value, so it shows the inverse.
  assign muxed_bus_in = muxed_bus_oe ? muxed_bus_out :
                        host_oe ? host_data : ~last_level;
  always @(posedge clk) last_level <= muxed_bus_in;
  initial begin
    cs_n = 1'b1;
    wr_pin = 1'b1;
    rd_pin = 1'b1;
    addr_data_sel = 1'b0;
  end
  // One byte access; select settles one cycle ahead of the strobes.
  task automatic xfer(input logic is_wr, input logic sel,
                      input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    addr_data_sel <= sel;
    host_oe <= is_wr;
    host_data <= d;
    @(posedge clk);
    cs_n <= 1'b0;
    wr_pin <= ~is_wr;
    rd_pin <= style_rw ? 1'b0 : is_wr;
    repeat (7) @(posedge clk);
    @(negedge clk);
    q = muxed_bus_in;
    @(posedge clk);
    cs_n <= 1'b1;
    wr_pin <= 1'b1;
    rd_pin <= 1'b1;
    host_oe <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// file: dv/rtcbus_core_tb.sv
`default_nettype none
// ==========================================================
// Self-checking bench for the host bus core
// ==========================================================
module rtcbus_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rtcbus_pkg::*;
  logic        clk, resetn, style_rw, power_fail_n, cs_n, wr_pin, rd_pin;
  logic        addr_data_sel, muxed_bus_oe, alarm_event, alarm_unmasked;
  logic        irq_n_out, irq_n_oe, tune_mode, pf_watch;
  logic [7:0]  muxed_bus_in, muxed_bus_out, trim_value, q, d;
  logic [7:0]  mem [256];
  logic [7:0]  hid [256];
  logic [7:0]  unm [4] = '{8'h03, 8'h29, 8'h35, 8'h60};
  logic [7:0]  cmds [3] = '{CMD_CLOCK, CMD_TIMER, CMD_BOTH};
  logic [31:0] lfsr;
  int          fail_count = 0;
  int          comparisons = 0;

  rtcbus_core i_dut (.clk, .resetn, .style_rw, .power_fail_n, .cs_n,
    .wr_pin, .rd_pin, .addr_data_sel, .muxed_bus_in, .muxed_bus_out,
    .muxed_bus_oe, .alarm_event, .alarm_unmasked, .irq_n_out, .irq_n_oe,
    .tune_mode, .trim_value);
  rtcbus_host_model i_host (.clk, .style_rw, .muxed_bus_out,
    .muxed_bus_oe, .cs_n, .wr_pin, .rd_pin, .addr_data_sel, .muxed_bus_in);

  always #10 clk = ~clk;

  // ==========================================================
  // Expectations and checks
  // ==========================================================
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] exp_status(input int k);
    return (k == 2) ? 8'h01 << STAT2_TUNE_BIT : STAT_RESET;
  endfunction
  // True where a command moves the copy at this address.
  function automatic bit moved(input logic [7:0] c, input int a);
    return (c != CMD_TIMER && a >= ADDR_CLK_FIRST && a <= ADDR_CLK_LAST) ||
           (c != CMD_CLOCK && a >= ADDR_TMR_FIRST && a <= ADDR_TMR_LAST);
  endfunction
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Address phase then data phase; ends off the edge so checks are settled.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    i_host.xfer(1'b1, 1'b0, a, q);
    i_host.xfer(1'b1, 1'b1, v, q);
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    i_host.xfer(1'b1, 1'b0, a, q);
    i_host.xfer(1'b0, 1'b1, BYTE_ZERO, v);
    @(negedge clk);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic fill(input int lo, input int hi);
    for (int a = lo; a <= hi; a++) begin
      lfsr = lfsr_next(lfsr);
      mem[a] = lfsr[7:0];
      wr(8'(a), mem[a]);
    end
  endtask
  task automatic verify(input int lo, input int hi);
    for (int a = lo; a <= hi; a++) begin
      rd(8'(a), d);
      check_byte(d, mem[a]);
    end
  endtask
  task automatic summarize();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Standby must never see the core drive the bus.
  always @(negedge clk) begin
    if (pf_watch) check_bit(muxed_bus_oe, 1'b0);
  end

  // Hang guard, well beyond the expected run length.
  initial begin
    #1_000_000;
    fail_count++;
    summarize();
  end

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    style_rw = 1'b0;
    power_fail_n = 1'b1;
    alarm_event = 1'b0;
    alarm_unmasked = 1'b0;
    pf_watch = 1'b0;
    lfsr = 32'h0001_12F6;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    // Registers are never read before they are written after power-up.
    for (int s = 0; s < 2; s++) begin
      repeat (2) @(posedge clk);
      style_rw <= s[0];
      wr(ADDR_STATUS2, 8'h10);
      i_host.xfer(1'b1, 1'b1, BYTE_ZERO, q);
      for (int k = 0; k < 3; k++) begin
        rd(8'(k), d);
        check_byte(d, exp_status(k));
      end
      check_bit(tune_mode, 1'b1);
      wr(ADDR_TRIM, 8'hD2);
      check_byte(trim_value, 8'hD2);
      i_host.xfer(1'b0, 1'b0, BYTE_ZERO, d);
      check_byte(d, ADDR_TRIM);
      i_host.xfer(1'b0, 1'b1, BYTE_ZERO, d);
      check_byte(d, 8'hD2);
      wr(ADDR_STATUS2, BYTE_ZERO);
      check_bit(tune_mode, 1'b0);
      fill(ADDR_USR_FIRST, ADDR_USR_LAST);
      fill(ADDR_ALM_FIRST, ADDR_ALM_LAST);
      foreach (unm[i]) begin
        wr(unm[i], 8'hA5);
        rd(unm[i], d);
        check_byte(d, BYTE_ZERO);
      end
      // Store, scribble over the copies, then load them back.
      foreach (cmds[j]) begin
        fill(ADDR_CLK_FIRST, ADDR_CLK_LAST);
        fill(ADDR_TMR_FIRST, ADDR_TMR_LAST);
        for (int a = 0; a < 256; a++) if (moved(cmds[j], a)) hid[a] = mem[a];
        wr(cmds[j], BYTE_ZERO);
        fill(ADDR_CLK_FIRST, ADDR_CLK_LAST);
        fill(ADDR_TMR_FIRST, ADDR_TMR_LAST);
        for (int a = 0; a < 256; a++) if (moved(cmds[j], a)) mem[a] = hid[a];
        rd(cmds[j], d);
        check_byte(d, BYTE_ZERO);
        verify(ADDR_CLK_FIRST, ADDR_CLK_LAST);
        verify(ADDR_TMR_FIRST, ADDR_TMR_LAST);
        verify(ADDR_USR_FIRST, ADDR_USR_LAST);
      end
      verify(ADDR_ALM_FIRST, ADDR_ALM_LAST);
    end
    // Standby: bus ignored and floating, alarm still reaches the request.
    @(posedge clk);
    power_fail_n <= 1'b0;
    settle(3);
    pf_watch = 1'b1;
    wr(ADDR_USR_FIRST, ~mem[ADDR_USR_FIRST]);
    rd(ADDR_USR_FIRST, d);
    @(posedge clk);
    alarm_event <= 1'b1;
    settle(5);
    check_bit(irq_n_oe, 1'b0);
    @(posedge clk);
    alarm_unmasked <= 1'b1;
    settle(5);
    check_bit(irq_n_oe, 1'b1);
    check_bit(irq_n_out, 1'b0);
    @(posedge clk);
    pf_watch = 1'b0;
    power_fail_n <= 1'b1;
    alarm_event <= 1'b0;
    alarm_unmasked <= 1'b0;
    settle(4);
    verify(ADDR_USR_FIRST, ADDR_USR_LAST);
    summarize();
  end
endmodule
`default_nettype wire
